/* File: hw/acc_defines.svh */
// Register offsets, field positions, masks and reset values for the ASI clock/channel bank.
// Included by the register bank, the host model and the bench; holds definitions only.
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH

// Control-bus target address (arbitrary value)
`define ACC_I2C_ADDR 7'h2a
// Register offsets
`define ACC_PAGE_OFS 8'h00
`define ACC_CLK_CFG_OFS 8'h0d
`define ACC_ADC_CFG_OFS 8'h0e
`define ACC_DAC_CFG_OFS 8'h0f
`define ACC_REG_PAGE 8'h00
// Field positions
`define ACC_PRI_OVR_BIT 7
`define ACC_SEC_OVR_BIT 6
`define ACC_PRI_INT_FS_BIT 2
`define ACC_SEC_INT_FS_BIT 1
`define ACC_FORCE_BIT 7
`define ACC_MASK_MSB 6
`define ACC_MASK_LSB 3
// Writable bits; reserved bits stay zero
`define ACC_CLK_CFG_WMASK 8'hc6
`define ACC_CH_CFG_WMASK 8'hf8
`define ACC_RESET_VAL 8'h00
// Bits per byte on the control bus
`define ACC_BYTE_BITS 4'h8
`define ACC_LAST_BIT 4'h7

`endif

/* File: hw/acc_pin_cond.sv */
// Control-bus pin conditioner: three-stage synchronisers on SCL and SDA,
// edge pulses and START/STOP detection. Pins are asynchronous to CLK.
`timescale 1ns/1ps
`default_nettype none

module acc_pin_cond
	import acc_pkg::*;
(
	input wire logic clk, // System clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic scl_pin, // Raw SCL
	input wire logic sda_pin, // Raw SDA
	output logic scl, // Filtered SCL level
	output logic sda, // Filtered SDA level
	output logic scl_rise, // One-cycle pulse on SCL rise
	output logic scl_fall, // One-cycle pulse on SCL fall
	output logic start, // START or repeated START
	output logic stop // STOP
);

	acc_cond_t st;
	acc_cond_t next_st;

	always_comb
	begin
		next_st = st;
		next_st.scl_sync = {st.scl_sync[1:0], scl_pin};
		next_st.sda_sync = {st.sda_sync[1:0], sda_pin};
		// A change counts once the second and third stages agree
		if (st.scl_sync[1] == st.scl_sync[2])
		begin
			next_st.scl = st.scl_sync[2];
		end
		if (st.sda_sync[1] == st.sda_sync[2])
		begin
			next_st.sda = st.sda_sync[2];
		end
		next_st.scl_rise = !st.scl && next_st.scl;
		next_st.scl_fall = st.scl && !next_st.scl;
		next_st.start = st.scl && next_st.scl && st.sda && !next_st.sda;
		next_st.stop = st.scl && next_st.scl && !st.sda && next_st.sda;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			st <= '{scl_sync: 3'h7, sda_sync: 3'h7, scl: 1'b1, sda: 1'b1, default: 1'b0};
		end
		else
		begin
			st <= next_st;
		end
	end

	assign scl = st.scl;
	assign sda = st.sda;
	assign scl_rise = st.scl_rise;
	assign scl_fall = st.scl_fall;
	assign start = st.start;
	assign stop = st.stop;

endmodule

`default_nettype wire

/* File: hw/acc_pkg.sv */
// Types shared by the ASI clock/channel register bank.
// Constants live in acc_defines.svh.
package acc_pkg;

typedef enum logic [3:0] {
	ST_IDLE = 4'b0000,
	ST_ADDR = 4'b0001,
	ST_ADDR_ACK = 4'b0010,
	ST_REG = 4'b0011,
	ST_REG_ACK = 4'b0100,
	ST_WDATA = 4'b0101,
	ST_WACK = 4'b0110,
	ST_RDATA = 4'b0111,
	ST_RACK = 4'b1000
} acc_state_t;

typedef struct packed {
	logic [2:0] scl_sync;
	logic [2:0] sda_sync;
	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start;
	logic stop;
} acc_cond_t;

typedef struct packed {
	acc_state_t state;
	logic [3:0] cnt;
	logic [7:0] shift;
	logic rw;
	logic [7:0] ptr;
	logic [7:0] page;
	logic [7:0] clk_cfg;
	logic [7:0] adc_cfg;
	logic [7:0] dac_cfg;
	logic sda_o;
	logic sda_oe_n;
	logic pri_bclk_out;
	logic pri_fsync_out;
	logic pri_auto_det;
	logic pri_int_fsync;
	logic sec_bclk_out;
	logic sec_fsync_out;
	logic sec_auto_det;
	logic sec_int_fsync;
	logic [3:0] adc_mask;
	logic [3:0] dac_mask;
} acc_regs_t;

endpackage

/* File: hw/acc_regs.sv */
// ASI clock-role and dynamic channel-limit register bank behind the control-bus
// target. Role selects and dynamic limit selectors come from same-clock logic.
//
// Functional notes
// - Primary override 0 follows role select; 1 disables autodetect
// - Primary override: select 0 BCLK in/FSYNC out
// - Secondary override 0 follows select; 1 disables autodetect
// - Secondary override: select 0 BCLK in/FSYNC out
// - Primary controller frame sync internal when bit set
// - Secondary controller frame sync internal when bit set
// - ADC force bit picks custom mask limit
// - ADC mask bits 6-3 enable channels 4-1
// - DAC force bit picks custom mask limit
// - DAC mask bits 6-3 enable channels 4-1
// - Page register at zero selects page
`timescale 1ns/1ps
`default_nettype none
`include "acc_defines.svh"

module acc_regs
	import acc_pkg::*;
(
	input wire logic CLK, // 250 MHz clock
	input wire logic RST, // Synchronous reset, active high
	input wire logic SCL_I, // Control-bus clock pin
	input wire logic SDA_I, // Control-bus data pin, input
	output logic SDA_O, // Control-bus data pin, output level (always 0)
	output logic SDA_OE_N, // Low while pulling SDA low
	input wire logic PRIMARY_ROLE_SELECT, // Primary controller/target select
	input wire logic SECONDARY_ROLE_SELECT, // Secondary controller/target select
	input wire logic [1:0] ADC_DYNAMIC_LIMIT_SELECT, // ADC dynamic max channels - 1
	input wire logic [1:0] DAC_DYNAMIC_LIMIT_SELECT, // DAC dynamic max channels - 1
	output logic PRI_BCLK_OUT, // Primary BCLK driven by device
	output logic PRI_FSYNC_OUT, // Primary FSYNC driven by device
	output logic PRI_AUTO_DETECT_EN, // Primary clock auto-detect available
	output logic PRI_INT_FSYNC, // Primary uses internal frame sync
	output logic SEC_BCLK_OUT, // Secondary BCLK driven by device
	output logic SEC_FSYNC_OUT, // Secondary FSYNC driven by device
	output logic SEC_AUTO_DETECT_EN, // Secondary clock auto-detect available
	output logic SEC_INT_FSYNC, // Secondary uses internal frame sync
	output logic [3:0] ADC_CH_MASK, // ADC dynamic-mode channel enables, bit 0 = ch 1
	output logic [3:0] DAC_CH_MASK // DAC dynamic-mode channel enables, bit 0 = ch 1
);

	acc_regs_t st;
	acc_regs_t next_st;
	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start;
	logic stop;

	acc_pin_cond u_pin_cond (
		.clk(CLK),
		.rst(RST),
		.scl_pin(SCL_I),
		.sda_pin(SDA_I),
		.scl(scl),
		.sda(sda),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.start(start),
		.stop(stop)
	);

	// Returns {bclk_out, fsync_out}
	function automatic logic [1:0] port_role(input logic ovr, input logic sel);
		port_role = ovr ? {sel, !sel} : {sel, sel};
	endfunction

	// Selector n gives the lowest n+1 channels
	function automatic logic [3:0] ch_limit(input logic [7:0] cfg, input logic [1:0] sel);
		ch_limit = cfg[`ACC_FORCE_BIT] ? cfg[`ACC_MASK_MSB:`ACC_MASK_LSB]
			: 4'hf >> ~sel;
	endfunction

	// Register read; offset 0 reads the page register on every page; unmapped addresses and other pages read zero
	function automatic logic [7:0] read_reg(input acc_regs_t s, input logic [7:0] a);
		logic [7:0] d;
		d = 8'h00;
		if (a == `ACC_PAGE_OFS)
		begin
			d = s.page;
		end
		else if (s.page == `ACC_REG_PAGE)
		begin
			case (a)
				`ACC_CLK_CFG_OFS: d = s.clk_cfg;
				`ACC_ADC_CFG_OFS: d = s.adc_cfg;
				`ACC_DAC_CFG_OFS: d = s.dac_cfg;
				default: d = 8'h00;
			endcase
		end
		read_reg = d;
	endfunction

	always_comb
	begin
		next_st = st;
		next_st.sda_o = 1'b0;
		{next_st.pri_bclk_out, next_st.pri_fsync_out} =
			port_role(st.clk_cfg[`ACC_PRI_OVR_BIT], PRIMARY_ROLE_SELECT);
		{next_st.sec_bclk_out, next_st.sec_fsync_out} =
			port_role(st.clk_cfg[`ACC_SEC_OVR_BIT], SECONDARY_ROLE_SELECT);
		next_st.pri_auto_det = !st.clk_cfg[`ACC_PRI_OVR_BIT];
		next_st.sec_auto_det = !st.clk_cfg[`ACC_SEC_OVR_BIT];
		// Controller mode: the device drives BCLK
		next_st.pri_int_fsync = PRIMARY_ROLE_SELECT && st.clk_cfg[`ACC_PRI_INT_FS_BIT];
		next_st.sec_int_fsync = SECONDARY_ROLE_SELECT && st.clk_cfg[`ACC_SEC_INT_FS_BIT];
		next_st.adc_mask = ch_limit(st.adc_cfg, ADC_DYNAMIC_LIMIT_SELECT);
		next_st.dac_mask = ch_limit(st.dac_cfg, DAC_DYNAMIC_LIMIT_SELECT);
		if (stop)
		begin
			next_st.state = ST_IDLE;
			next_st.sda_oe_n = 1'b1;
		end
		else if (start)
		begin
			next_st.state = ST_ADDR;
			next_st.cnt = 4'h0;
			next_st.sda_oe_n = 1'b1;
		end
		else
		begin
			case (st.state)
				ST_IDLE:
				begin
					next_st.sda_oe_n = 1'b1;
				end
				ST_ADDR, ST_REG, ST_WDATA:
				begin
					if (scl_rise)
					begin
						next_st.shift = {st.shift[6:0], sda};
						next_st.cnt = st.cnt + 4'h1;
					end
					else if (scl_fall && st.cnt == `ACC_BYTE_BITS)
					begin
						next_st.cnt = 4'h0;
						next_st.sda_oe_n = 1'b0;
						if (st.state == ST_ADDR)
						begin
							next_st.rw = st.shift[0];
							next_st.state = ST_ADDR_ACK;
							if (st.shift[7:1] != `ACC_I2C_ADDR)
							begin
								next_st.sda_oe_n = 1'b1;
								next_st.state = ST_IDLE;
							end
						end
						else if (st.state == ST_REG)
						begin
							next_st.ptr = st.shift;
							next_st.state = ST_REG_ACK;
						end
						else
						begin
							// Write takes effect at the end of the byte
							if (st.ptr == `ACC_PAGE_OFS)
							begin
								next_st.page = st.shift;
							end
							else if (st.page == `ACC_REG_PAGE)
							begin
								case (st.ptr)
									`ACC_CLK_CFG_OFS: next_st.clk_cfg = st.shift & `ACC_CLK_CFG_WMASK;
									`ACC_ADC_CFG_OFS: next_st.adc_cfg = st.shift & `ACC_CH_CFG_WMASK;
									`ACC_DAC_CFG_OFS: next_st.dac_cfg = st.shift & `ACC_CH_CFG_WMASK;
									default: next_st.page = st.page;
								endcase
							end
							next_st.ptr = st.ptr + 8'h01;
							next_st.state = ST_WACK;
						end
					end
				end
				ST_ADDR_ACK, ST_REG_ACK, ST_WACK:
				begin
					if (scl_fall)
					begin
						next_st.sda_oe_n = 1'b1;
						next_st.cnt = 4'h0;
						next_st.state = (st.state == ST_ADDR_ACK) ? ST_REG : ST_WDATA;
						if (st.state == ST_ADDR_ACK && st.rw)
						begin
							next_st.shift = read_reg(st, st.ptr);
							next_st.sda_oe_n = next_st.shift[7];
							next_st.ptr = st.ptr + 8'h01;
							next_st.state = ST_RDATA;
						end
					end
				end
				ST_RDATA:
				begin
					if (scl_fall)
					begin
						if (st.cnt == `ACC_LAST_BIT)
						begin
							next_st.sda_oe_n = 1'b1;
							next_st.cnt = 4'h0;
							next_st.state = ST_RACK;
						end
						else
						begin
							next_st.shift = {st.shift[6:0], 1'b0};
							next_st.sda_oe_n = st.shift[6];
							next_st.cnt = st.cnt + 4'h1;
						end
					end
				end
				ST_RACK:
				begin
					if (scl_rise && sda)
					begin
						next_st.state = ST_IDLE;
					end
					else if (scl_fall)
					begin
						next_st.shift = read_reg(st, st.ptr);
						next_st.sda_oe_n = next_st.shift[7];
						next_st.ptr = st.ptr + 8'h01;
						next_st.state = ST_RDATA;
					end
				end
				default:
				begin
					next_st.state = ST_IDLE;
					next_st.sda_oe_n = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			st <= '{state: ST_IDLE, sda_oe_n: 1'b1, pri_auto_det: 1'b1, sec_auto_det: 1'b1,
				adc_mask: 4'h1, dac_mask: 4'h1, default: '0};
		end
		else
		begin
			st <= next_st;
		end
	end

	assign {SDA_O, SDA_OE_N} = {st.sda_o, st.sda_oe_n};
	assign {PRI_BCLK_OUT, PRI_FSYNC_OUT, PRI_AUTO_DETECT_EN, PRI_INT_FSYNC} =
		{st.pri_bclk_out, st.pri_fsync_out, st.pri_auto_det, st.pri_int_fsync};
	assign {SEC_BCLK_OUT, SEC_FSYNC_OUT, SEC_AUTO_DETECT_EN, SEC_INT_FSYNC} =
		{st.sec_bclk_out, st.sec_fsync_out, st.sec_auto_det, st.sec_int_fsync};
	assign {ADC_CH_MASK, DAC_CH_MASK} = {st.adc_mask, st.dac_mask};

	pri_standard_a: assert property (@(posedge CLK) disable iff (RST)
		!st.clk_cfg[7] |=> PRI_AUTO_DETECT_EN && PRI_FSYNC_OUT == PRI_BCLK_OUT)
		else $error("primary standard role wrong");
	pri_override_a: assert property (@(posedge CLK) disable iff (RST)
		st.clk_cfg[7] |=> !PRI_AUTO_DETECT_EN && PRI_FSYNC_OUT == !$past(PRIMARY_ROLE_SELECT)
		&& PRI_BCLK_OUT == $past(PRIMARY_ROLE_SELECT))
		else $error("primary override role wrong");
	sec_standard_a: assert property (@(posedge CLK) disable iff (RST)
		!st.clk_cfg[6] |=> SEC_AUTO_DETECT_EN && SEC_FSYNC_OUT == SEC_BCLK_OUT)
		else $error("secondary standard role wrong");
	sec_override_a: assert property (@(posedge CLK) disable iff (RST)
		st.clk_cfg[6] |=> !SEC_AUTO_DETECT_EN && SEC_BCLK_OUT == $past(SECONDARY_ROLE_SELECT)
		&& SEC_FSYNC_OUT != SEC_BCLK_OUT)
		else $error("secondary override role wrong");
	pri_int_fsync_a: assert property (@(posedge CLK) disable iff (RST)
		PRI_INT_FSYNC |-> $past(st.clk_cfg[2]) && $past(PRIMARY_ROLE_SELECT))
		else $error("primary internal fsync without cause");
	sec_int_fsync_a: assert property (@(posedge CLK) disable iff (RST)
		(st.clk_cfg[1] && SECONDARY_ROLE_SELECT) |=> SEC_INT_FSYNC)
		else $error("secondary internal fsync missing");
	adc_custom_a: assert property (@(posedge CLK) disable iff (RST)
		st.adc_cfg[7] |=> ADC_CH_MASK == $past(st.adc_cfg[6:3]))
		else $error("adc custom limit not applied");
	dac_select_a: assert property (@(posedge CLK) disable iff (RST)
		(!st.dac_cfg[7] && DAC_DYNAMIC_LIMIT_SELECT == 2'h1) |=> DAC_CH_MASK == 4'h3)
		else $error("dac selector limit wrong");
	reserved_zero_a: assert property (@(posedge CLK) disable iff (RST)
		(st.clk_cfg & 8'h39) == 8'h00 && st.adc_cfg[2:0] == 3'h0 && st.dac_cfg[2:0] == 3'h0)
		else $error("reserved bit set");
	paged_write_a: assert property (@(posedge CLK) disable iff (RST)
		$changed(st.dac_cfg) |-> $past(st.page) == 8'h00 && $past(st.state) == ST_WDATA)
		else $error("register changed off page zero");
	reset_zero_a: assert property (@(posedge CLK)
		$past(RST) |-> st.clk_cfg == 8'h00 && st.adc_cfg == 8'h00 && st.page == 8'h00)
		else $error("register not zero after reset");

endmodule

`default_nettype wire

/* File: verif/acc_host.sv */
// Behavioural control-bus host for the clock/channel register bank.
// Assumes a pull-up on SDA: the wire is low when either side pulls it.
`timescale 1ns/1ps
`default_nettype none
`include "acc_defines.svh"

module acc_host
	import acc_pkg::*;
(
	input wire logic clk, // Bank clock, paces the bus
	input wire logic sda_oe_n, // Bank pulls SDA low when 0
	output logic scl, // Bus clock
	output logic sda_w // Resolved SDA level
);
	logic sda;
	assign sda_w = sda & sda_oe_n;
	initial
	begin
		scl = 1'b1;
		sda = 1'b1;
	end
	task automatic half();
		repeat (10) @(negedge clk);
	endtask
	task automatic start_c();
		sda = 1'b1;
		half();
		scl = 1'b1;
		half();
		sda = 1'b0;
		half();
		scl = 1'b0;
		half();
	endtask
	task automatic stop_c();
		sda = 1'b0;
		half();
		scl = 1'b1;
		half();
		sda = 1'b1;
		half();
	endtask
	// Nine bits MSB first; a 1 releases SDA so the bank may answer
	task automatic xfer(input logic [8:0] d, output logic [8:0] r);
		for (int i = 8; i >= 0; i--)
		begin
			sda = d[i];
			half();
			scl = 1'b1;
			half();
			r[i] = sda_w;
			scl = 1'b0;
			half();
		end
	endtask
	task automatic write(input logic [7:0] ofs, input logic [7:0] d, output logic ok);
		logic [8:0] r0, r1, r2;
		start_c();
		xfer({`ACC_I2C_ADDR, 2'b01}, r0);
		xfer({ofs, 1'b1}, r1);
		xfer({d, 1'b1}, r2);
		stop_c();
		ok = !(r0[0] | r1[0] | r2[0]);
	endtask
	// Last ninth bit left high: not-acknowledge ends the read
	task automatic read(input logic [7:0] ofs, output logic [7:0] d, output logic ok);
		logic [8:0] r0, r1, r2, r3;
		start_c();
		xfer({`ACC_I2C_ADDR, 2'b01}, r0);
		xfer({ofs, 1'b1}, r1);
		start_c();
		xfer({`ACC_I2C_ADDR, 2'b11}, r2);
		xfer(9'h1ff, r3);
		stop_c();
		d = r3[8:1];
		ok = !(r0[0] | r1[0] | r2[0]);
	endtask
endmodule

`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench for the clock/channel register bank.
// Assumes the host model in acc_host.sv drives the control bus.
`timescale 1ns/1ps
`default_nettype none
`include "acc_defines.svh"

module tb
	import acc_pkg::*;
;
	logic clk, rst, pri_sel, sec_sel, scl, sda_w, sda_o, sda_oe_n;
	logic [1:0] adc_sel, dac_sel;
	wire logic [3:0] pri, sec, adc_mask, dac_mask;
	int num_errors, checked;
	acc_regs i_acc_regs(.CLK(clk), .RST(rst), .SCL_I(scl), .SDA_I(sda_w), .SDA_O(sda_o),
		.SDA_OE_N(sda_oe_n), .PRIMARY_ROLE_SELECT(pri_sel), .SECONDARY_ROLE_SELECT(sec_sel),
		.ADC_DYNAMIC_LIMIT_SELECT(adc_sel), .DAC_DYNAMIC_LIMIT_SELECT(dac_sel),
		.PRI_BCLK_OUT(pri[3]), .PRI_FSYNC_OUT(pri[2]), .PRI_AUTO_DETECT_EN(pri[1]),
		.PRI_INT_FSYNC(pri[0]), .SEC_BCLK_OUT(sec[3]), .SEC_FSYNC_OUT(sec[2]),
		.SEC_AUTO_DETECT_EN(sec[1]), .SEC_INT_FSYNC(sec[0]), .ADC_CH_MASK(adc_mask),
		.DAC_CH_MASK(dac_mask));
	acc_host i_acc_host(.clk(clk), .sda_oe_n(sda_oe_n), .scl(scl), .sda_w(sda_w));
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic ok;
		i_acc_host.write(a, d, ok);
		chk({7'h0, ok}, 8'h01, "write ack");
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic ok;
		logic [7:0] d;
		i_acc_host.read(a, d, ok);
		chk({7'h0, ok}, 8'h01, "read ack");
		chk(d, exp, "read data");
	endtask
	// Expected {bclk out, fsync out, auto-detect, internal fsync}
	function automatic logic [3:0] role(input logic ovr, input logic fs, input logic sel);
		return {sel, ovr ? !sel : sel, !ovr, sel & fs};
	endfunction
	task automatic t_reset();
		pri_sel = 1'b0;
		sec_sel = 1'b0;
		adc_sel = 2'b00;
		dac_sel = 2'b00;
		rst = 1'b1;
		repeat (12) @(negedge clk);
		rst = 1'b0;
		repeat (8) @(negedge clk);
		chk({pri, sec}, 8'h22, "roles after reset");
		chk({adc_mask, dac_mask}, 8'h11, "limits after reset");
		chk({6'h0, sda_o, sda_oe_n}, 8'h01, "data pin after reset");
		for (int a = 13; a < 16; a++)
			rd_chk(8'(a), 8'h00);
		$display("reset test done");
	endtask
	task automatic t_roles();
		logic [7:0] v [4] = '{8'h00, 8'hc6, 8'h84, 8'h42};
		for (int i = 0; i < 4; i++)
		begin
			wr(`ACC_CLK_CFG_OFS, v[i]);
			rd_chk(`ACC_CLK_CFG_OFS, v[i]);
			for (int s = 0; s < 2; s++)
			begin
				pri_sel = s[0];
				sec_sel = !s[0];
				repeat (2) @(negedge clk);
				chk({4'h0, pri}, {4'h0, role(v[i][7], v[i][2], s[0])}, "primary");
				chk({4'h0, sec}, {4'h0, role(v[i][6], v[i][1], !s[0])}, "secondary");
			end
		end
		$display("roles test done");
	endtask
	task automatic t_masks();
		logic [3:0] m [4] = '{4'h1, 4'h3, 4'h7, 4'hf};
		for (int s = 0; s < 4; s++)
		begin
			adc_sel = 2'(s);
			dac_sel = 2'(3 - s);
			repeat (2) @(negedge clk);
			chk({adc_mask, dac_mask}, {m[s], m[3 - s]}, "selector limit");
		end
		wr(`ACC_ADC_CFG_OFS, 8'hd0);
		wr(`ACC_DAC_CFG_OFS, 8'ha8);
		repeat (2) @(negedge clk);
		chk({adc_mask, dac_mask}, 8'ha5, "custom limit");
		wr(`ACC_ADC_CFG_OFS, 8'h50);
		repeat (2) @(negedge clk);
		chk({adc_mask, dac_mask}, 8'hf5, "force cleared");
		$display("masks test done");
	endtask
	// Deliberately sets reserved bits to see them dropped
	task automatic t_reserved();
		wr(`ACC_CLK_CFG_OFS, 8'hff);
		rd_chk(`ACC_CLK_CFG_OFS, 8'hc6);
		wr(`ACC_DAC_CFG_OFS, 8'hff);
		rd_chk(`ACC_DAC_CFG_OFS, 8'hf8);
		$display("reserved test done");
	endtask
	task automatic t_page();
		wr(`ACC_PAGE_OFS, 8'h01);
		rd_chk(`ACC_PAGE_OFS, 8'h01);
		wr(`ACC_CLK_CFG_OFS, 8'h00);
		rd_chk(`ACC_CLK_CFG_OFS, 8'h00);
		wr(`ACC_PAGE_OFS, 8'h00);
		rd_chk(`ACC_CLK_CFG_OFS, 8'hc6);
		$display("page test done");
	endtask
	initial
	begin
		repeat (90000) @(posedge clk);
		num_errors++;
		$display("BAD %0t watchdog expired", $time);
		give_verdict();
	end
	initial
	begin
		num_errors = 0;
		checked = 0;
		t_reset();
		t_roles();
		t_masks();
		t_reserved();
		t_page();
		t_reset();
		give_verdict();
	end
endmodule

`default_nettype wire
